// ==== rfc_defines.svh ====
// Register offsets, field positions, reset values and sizes of the converter
`ifndef RFC_DEFINES_SVH
`define RFC_DEFINES_SVH

`define RFC_CHANNELS        19
`define RFC_COUNT_W         15
`define RFC_SEL_W           5

`define RFC_OFS_CTRL        8'h00
`define RFC_OFS_COUNT_LO    8'h04
`define RFC_OFS_COUNT_HI    8'h08
`define RFC_OFS_IFLAG       8'h0c
`define RFC_OFS_IEN         8'h10

`define RFC_CTRL_EN_BIT     7
`define RFC_CTRL_START_BIT  6
`define RFC_CTRL_SEL_LSB    0
`define RFC_DONE_BIT        6

`define RFC_CTRL_RST        8'h00
`define RFC_IFLAG_RST       1'b0
`define RFC_IEN_RST         1'b0
`define RFC_COUNT_RST       15'h0000

`define RFC_HSIZE_WORD      3'h2
`define RFC_HTRANS_NONSEQ   2'h2

`endif

// ==== rfc_pkg.sv ====
// Types shared by the converter modules
package rfc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARM,
        ST_COUNT,
        ST_TAIL
    } meas_state_e;

    typedef enum logic [2:0] {
        SEL_CTRL,
        SEL_COUNT_LO,
        SEL_COUNT_HI,
        SEL_IFLAG,
        SEL_IEN,
        SEL_NONE
    } reg_sel_e;

endpackage

// ==== pin_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    generate
        if (WIDTH < 1)
        begin : g_chk
            $error("pin_sync width must be at least one");
        end
    endgenerate

    // First stage feeds only the second
    always_comb
    begin
        meta_next = d;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign q = sync_reg;

endmodule

`default_nettype wire

// ==== drive_mux.sv ====
// Steers each shared pin between port logic and the converter drive
`timescale 1ns/1ps
`default_nettype none

module drive_mux #(
    parameter int CHANNELS = 19,
    parameter int SEL_W    = 5
) (
    input  wire logic                enable,
    input  wire logic [SEL_W-1:0]    sel,
    input  wire logic [CHANNELS-1:0] gpio_o,
    input  wire logic [CHANNELS-1:0] gpio_oe,
    output var  logic [CHANNELS-1:0] pad_o,
    output var  logic [CHANNELS-1:0] pad_oe
);

    generate
        if (CHANNELS < 1 || CHANNELS > (1 << SEL_W))
        begin : g_chk
            $error("drive_mux channel count does not fit the select field");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++)
        begin : g_pin
            always_comb
            begin
                if (!enable)
                begin
                    pad_o[i]  = gpio_o[i];                  // RL2
                    pad_oe[i] = gpio_oe[i];
                end
                else if (sel == SEL_W'(i))
                begin
                    pad_o[i]  = 1'b0;                       // RL7
                    pad_oe[i] = 1'b1;                       // RL1
                end
                else
                begin
                    // Unselected pins float so no second network can run
                    pad_o[i]  = 1'b0;
                    pad_oe[i] = 1'b0;                       // RL5
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ==== rfc_converter.sv ====
// Resistor-to-frequency converter with AHB-Lite register slave
//
// Function
// (RL1) The five-bit select field picks one of pins 0 to 18 to become the converter output while enabled, the rest float.
// (RL2) With the module disabled every shared drive pin and the timing pin belong to the port logic.
// (RL3) With the module enabled the port A bit 1 pin is the timing input and the selected pin is the drive output.
// (RL4) Writing start as one begins a conversion, hardware clears it at the end, writing it as zero aborts.
// (RL5) At most one oscillation network is ever active.
// (RL6) The 15-bit counter clears on any control write, while the enable is clear, and on reset.
// (RL7) The selected drive pin drives low and all unselected drive pins float.
// (RL8) Network and counter stay inactive until start is set; the code drives the selected pin low as soon as enable is set.
// (RL9) Software sets all used drive pins and the timing pin to input before enabling.
// (RL10) The counter counts system clocks and the timing input only gates the window.
// (RL11) Counting begins at the first timing rising edge after enable and start.
// (RL12) Counting stops at the second rising edge, so one full period is held.
// (RL13) At the second falling edge start clears and the done flag sets when its enable is set.
// (RL14) The done interrupt is masked by clearing its enable bit.
// (RL15) The finished count stays readable in low and high byte registers until cleared or restarted.
`timescale 1ns/1ps
`default_nettype none

`include "rfc_defines.svh"

module rfc_converter #(
    parameter int CHANNELS = `RFC_CHANNELS,
    parameter int COUNT_W  = `RFC_COUNT_W
) (
    input  wire logic                CLK_SYS,
    input  wire logic                SRST,
    input  wire logic                HSEL,
    input  wire logic [31:0]         HADDR,
    input  wire logic [1:0]          HTRANS,
    input  wire logic                HWRITE,
    input  wire logic [2:0]          HSIZE,
    input  wire logic [31:0]         HWDATA,
    input  wire logic                HREADY,
    output var  logic [31:0]         HRDATA,
    output var  logic                HREADYOUT,
    output var  logic                HRESP,
    output var  logic                IRQ,
    input  wire logic                TIMING_INPUT_PIN_I,
    input  wire logic                PORT_A_BIT1_PIN_O,
    input  wire logic                PORT_A_BIT1_PIN_OE,
    output var  logic                PORT_A_BIT1_PIN_IN,
    output var  logic                TIMING_INPUT_PIN_O,
    output var  logic                TIMING_INPUT_PIN_OE,
    input  wire logic [CHANNELS-1:0] GPIO_O,
    input  wire logic [CHANNELS-1:0] GPIO_OE,
    output var  logic [CHANNELS-1:0] SENSOR_DRIVE_PIN_O,
    output var  logic [CHANNELS-1:0] SENSOR_DRIVE_PIN_OE
);

    localparam int SEL_W = `RFC_SEL_W;

    generate
        if (COUNT_W < 9 || COUNT_W > 16)
        begin : g_chk_count
            $error("rfc_converter count width must lie between 9 and 16");
        end
        if (CHANNELS < 1 || CHANNELS > (1 << SEL_W))
        begin : g_chk_chan
            $error("rfc_converter channel count does not fit the select field");
        end
    endgenerate

    function automatic rfc_pkg::reg_sel_e decode(input logic [31:0] addr);
        rfc_pkg::reg_sel_e s;
        s = rfc_pkg::SEL_NONE;
        if (addr[31:8] == 24'h000000)
        begin
            case (addr[7:0])
                `RFC_OFS_CTRL:     s = rfc_pkg::SEL_CTRL;
                `RFC_OFS_COUNT_LO: s = rfc_pkg::SEL_COUNT_LO;
                `RFC_OFS_COUNT_HI: s = rfc_pkg::SEL_COUNT_HI;
                `RFC_OFS_IFLAG:    s = rfc_pkg::SEL_IFLAG;
                `RFC_OFS_IEN:      s = rfc_pkg::SEL_IEN;
                default:           s = rfc_pkg::SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // Control and status
    logic                   enable_reg;
    logic                   enable_next;
    logic                   start_reg;
    logic                   start_next;
    logic [SEL_W-1:0]       sel_reg;
    logic [SEL_W-1:0]       sel_next;
    logic [COUNT_W-1:0]     count_reg;
    logic [COUNT_W-1:0]     count_next;
    logic                   done_flag_reg;
    logic                   done_flag_next;
    logic                   done_ien_reg;
    logic                   done_ien_next;
    rfc_pkg::meas_state_e   state_reg;
    rfc_pkg::meas_state_e   state_next;

    // Bus slave
    logic                   wr_pend_reg;
    logic                   wr_pend_next;
    rfc_pkg::reg_sel_e      wr_sel_reg;
    rfc_pkg::reg_sel_e      wr_sel_next;
    logic [31:0]            hrdata_reg;
    logic [31:0]            hrdata_next;
    logic                   irq_reg;
    logic                   irq_next;

    // Pins
    logic                   timing_sync;
    logic                   timing_prev_reg;
    logic                   timing_prev_next;
    logic                   port_in_reg;
    logic                   port_in_next;
    logic                   tpad_o_reg;
    logic                   tpad_o_next;
    logic                   tpad_oe_reg;
    logic                   tpad_oe_next;
    logic [CHANNELS-1:0]    pad_o_reg;
    logic [CHANNELS-1:0]    pad_o_comb;
    logic [CHANNELS-1:0]    pad_oe_reg;
    logic [CHANNELS-1:0]    pad_oe_comb;

    logic                   addr_valid;
    logic                   timing_rise;
    logic                   timing_fall;
    logic                   done_event;
    logic                   ctrl_write;
    logic [7:0]             ctrl_read;

    pin_sync #(
        .WIDTH (1)
    ) u_timing_sync (
        .clk  (CLK_SYS),
        .srst (SRST),
        .d    (TIMING_INPUT_PIN_I),
        .q    (timing_sync)
    );

    drive_mux #(
        .CHANNELS (CHANNELS),
        .SEL_W    (SEL_W)
    ) u_drive_mux (
        .enable  (enable_reg),
        .sel     (sel_reg),
        .gpio_o  (GPIO_O),
        .gpio_oe (GPIO_OE),
        .pad_o   (pad_o_comb),
        .pad_oe  (pad_oe_comb)
    );

    assign addr_valid  = HSEL && HREADY && (HTRANS == `RFC_HTRANS_NONSEQ);
    assign timing_rise = timing_sync && !timing_prev_reg;
    assign timing_fall = !timing_sync && timing_prev_reg;
    assign ctrl_write  = wr_pend_reg && (wr_sel_reg == rfc_pkg::SEL_CTRL);

    always_comb
    begin
        ctrl_read = 8'h00;
        ctrl_read[`RFC_CTRL_EN_BIT] = enable_reg;
        ctrl_read[`RFC_CTRL_START_BIT] = start_reg;
        ctrl_read[`RFC_CTRL_SEL_LSB +: SEL_W] = sel_reg;
    end

    // Measurement sequence, then register writes on top of it
    always_comb
    begin
        enable_next    = enable_reg;
        start_next     = start_reg;
        sel_next       = sel_reg;
        count_next     = count_reg;
        done_flag_next = done_flag_reg;
        done_ien_next  = done_ien_reg;
        state_next     = state_reg;
        done_event     = 1'b0;

        case (state_reg)
            rfc_pkg::ST_IDLE:
            begin
                state_next = rfc_pkg::ST_IDLE;                          // RL8
            end
            rfc_pkg::ST_ARM:
            begin
                if (timing_rise)
                begin
                    count_next = count_reg + COUNT_W'(1);               // RL12
                    state_next = rfc_pkg::ST_COUNT;                     // RL11
                end
            end
            rfc_pkg::ST_COUNT:
            begin
                if (timing_rise)
                begin
                    state_next = rfc_pkg::ST_TAIL;                      // RL12
                end
                else if (count_reg != {COUNT_W{1'b1}})
                begin
                    // Saturates rather than wrap on a stuck network
                    count_next = count_reg + COUNT_W'(1);               // RL10
                end
            end
            rfc_pkg::ST_TAIL:
            begin
                if (timing_fall)
                begin
                    done_event = 1'b1;
                    start_next = 1'b0;                                  // RL13
                    state_next = rfc_pkg::ST_IDLE;                      // RL15
                end
            end
            default:
            begin
                state_next = rfc_pkg::ST_IDLE;
            end
        endcase

        // Clearing wins over nothing; setting wins over the software clear
        if (wr_pend_reg && wr_sel_reg == rfc_pkg::SEL_IFLAG && HWDATA[`RFC_DONE_BIT])
        begin
            done_flag_next = 1'b0;
        end
        if (done_event && done_ien_reg)
        begin
            done_flag_next = 1'b1;                                      // RL13
        end

        if (wr_pend_reg && wr_sel_reg == rfc_pkg::SEL_IEN)
        begin
            done_ien_next = HWDATA[`RFC_DONE_BIT];                      // RL14
        end

        if (ctrl_write)
        begin
            enable_next = HWDATA[`RFC_CTRL_EN_BIT];
            sel_next    = HWDATA[`RFC_CTRL_SEL_LSB +: SEL_W];
            start_next  = HWDATA[`RFC_CTRL_START_BIT];
            count_next  = '0;                                           // RL6
            if (HWDATA[`RFC_CTRL_START_BIT])
            begin
                state_next = rfc_pkg::ST_ARM;                           // RL4
            end
            else
            begin
                state_next = rfc_pkg::ST_IDLE;                          // RL4
            end
        end

        if (!enable_next)
        begin
            start_next = 1'b0;
            count_next = '0;                                            // RL6
            state_next = rfc_pkg::ST_IDLE;
        end
    end

    // AHB-Lite slave: zero wait states, read data fetched in the address phase
    always_comb
    begin
        wr_pend_next = 1'b0;
        wr_sel_next  = rfc_pkg::SEL_NONE;
        hrdata_next  = hrdata_reg;
        if (addr_valid)
        begin
            if (HWRITE)
            begin
                // Narrow writes are ignored; only whole words reach registers
                wr_pend_next = (HSIZE == `RFC_HSIZE_WORD);
                wr_sel_next  = decode(HADDR);
            end
            else
            begin
                case (decode(HADDR))
                    rfc_pkg::SEL_CTRL:     hrdata_next = {24'h000000, ctrl_read};
                    rfc_pkg::SEL_COUNT_LO: hrdata_next = {24'h000000, count_reg[7:0]}; // RL15
                    rfc_pkg::SEL_COUNT_HI: hrdata_next = 32'(count_reg[COUNT_W-1:8]);
                    rfc_pkg::SEL_IFLAG:    hrdata_next = 32'(done_flag_reg) << `RFC_DONE_BIT;
                    rfc_pkg::SEL_IEN:      hrdata_next = 32'(done_ien_reg) << `RFC_DONE_BIT;
                    default:               hrdata_next = 32'h00000000;
                endcase
            end
        end
        irq_next = done_flag_next && done_ien_next;                     // RL14
    end

    // Pin steering
    always_comb
    begin
        timing_prev_next = timing_sync;
        if (enable_reg)
        begin
            // Pin released to the external network while the module owns it
            tpad_o_next  = 1'b0;
            tpad_oe_next = 1'b0;                                        // RL3
            port_in_next = 1'b0;
        end
        else
        begin
            tpad_o_next  = PORT_A_BIT1_PIN_O;                           // RL2
            tpad_oe_next = PORT_A_BIT1_PIN_OE;
            port_in_next = timing_sync;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            enable_reg      <= 1'b0;
            start_reg       <= 1'b0;
            sel_reg         <= '0;
            count_reg       <= '0;                                      // RL6
            done_flag_reg   <= `RFC_IFLAG_RST;
            done_ien_reg    <= `RFC_IEN_RST;
            state_reg       <= rfc_pkg::ST_IDLE;
            wr_pend_reg     <= 1'b0;
            wr_sel_reg      <= rfc_pkg::SEL_NONE;
            hrdata_reg      <= 32'h00000000;
            irq_reg         <= 1'b0;
            timing_prev_reg <= 1'b0;
            port_in_reg     <= 1'b0;
            tpad_o_reg      <= 1'b0;
            tpad_oe_reg     <= 1'b0;
            pad_o_reg       <= '0;
            pad_oe_reg      <= '0;
        end
        else
        begin
            enable_reg      <= enable_next;
            start_reg       <= start_next;
            sel_reg         <= sel_next;
            count_reg       <= count_next;
            done_flag_reg   <= done_flag_next;
            done_ien_reg    <= done_ien_next;
            state_reg       <= state_next;
            wr_pend_reg     <= wr_pend_next;
            wr_sel_reg      <= wr_sel_next;
            hrdata_reg      <= hrdata_next;
            irq_reg         <= irq_next;
            timing_prev_reg <= timing_prev_next;
            port_in_reg     <= port_in_next;
            tpad_o_reg      <= tpad_o_next;
            tpad_oe_reg     <= tpad_oe_next;
            pad_o_reg       <= pad_o_comb;                              // RL1
            pad_oe_reg      <= pad_oe_comb;                             // RL5
        end
    end

    assign HRDATA              = hrdata_reg;
    assign HREADYOUT           = !SRST || 1'b1;
    assign HRESP               = 1'b0;
    assign IRQ                 = irq_reg;
    assign PORT_A_BIT1_PIN_IN  = port_in_reg;
    assign TIMING_INPUT_PIN_O  = tpad_o_reg;
    assign TIMING_INPUT_PIN_OE = tpad_oe_reg;
    assign SENSOR_DRIVE_PIN_O  = pad_o_reg;
    assign SENSOR_DRIVE_PIN_OE = pad_oe_reg;

endmodule

`default_nettype wire

// ==== rc_network.sv ====
// Behavioural model of the external RC sensor networks on the timing pad
`timescale 1ns/1ps
`default_nettype none

module rc_network (
    input  wire logic        clk,
    input  wire logic [18:0] drive_o,
    input  wire logic [18:0] drive_oe,
    input  wire logic        run,
    input  var  int          half,
    output var  logic        cx
);
    int   tick;
    logic live;

    // One grounded drive pin closes the loop; none or two leaves the network dead
    assign live = run && $onehot(drive_oe) && ((drive_o & drive_oe) == 19'h0);

    // Capacitor discharged while dead, so the pad rests low
    always @(posedge clk)
    begin
        if (!live)
        begin
            tick <= 0;
            cx   <= 1'b0;
        end
        else if (tick >= half - 1)
        begin
            tick <= 0;
            cx   <= ~cx;
        end
        else
            tick <= tick + 1;
    end
endmodule

`default_nettype wire

// ==== rfc_converter_asserts.sv ====
// Port-level checker for the converter
`timescale 1ns/1ps
`default_nettype none

module rfc_converter_asserts #(
    parameter int CHANNELS = 19
) (
    input wire logic                CLK_SYS,
    input wire logic                SRST,
    input wire logic                HSEL,
    input wire logic [31:0]         HADDR,
    input wire logic [1:0]          HTRANS,
    input wire logic                HWRITE,
    input wire logic [31:0]         HWDATA,
    input wire logic                HREADY,
    input wire logic [31:0]         HRDATA,
    input wire logic                IRQ,
    input wire logic                TIMING_INPUT_PIN_I,
    input wire logic                PORT_A_BIT1_PIN_OE,
    input wire logic                TIMING_INPUT_PIN_OE,
    input wire logic [CHANNELS-1:0] GPIO_O,
    input wire logic [CHANNELS-1:0] GPIO_OE,
    input wire logic [CHANNELS-1:0] SENSOR_DRIVE_PIN_O,
    input wire logic [CHANNELS-1:0] SENSOR_DRIVE_PIN_OE
);
    logic                take, wc_reg, wc_next, wi_reg, wi_next, en_reg, en_next;
    logic                en_d_reg, en_d_next, ien_reg, ien_next;
    logic                cx_reg, cx_next;
    logic [4:0]          sel_reg, sel_next, sel_d_reg, sel_d_next;
    logic [3:0]          fall_reg, fall_next;
    logic [31:0]         rm_reg, rm_next;
    logic [CHANNELS-1:0] sel_oh;

    // Shadow lags one edge more than the register so it lines up with the pads
    always_comb
    begin
        take       = HSEL && HREADY && HTRANS == 2'h2;
        wc_next    = take && HWRITE && HADDR == 32'h0;
        wi_next    = take && HWRITE && HADDR == 32'h10;
        rm_next    = 32'h0;
        if (take && !HWRITE && HADDR == 32'h8)
            rm_next = 32'hffffff80;
        else if (take && !HWRITE && !(HADDR inside {32'h0, 32'h4, 32'hc, 32'h10}))
            rm_next = 32'hffffffff;
        en_next    = wc_reg ? HWDATA[7] : en_reg;
        sel_next   = wc_reg ? HWDATA[4:0] : sel_reg;
        ien_next   = wi_reg ? HWDATA[6] : ien_reg;
        en_d_next  = en_reg;
        sel_d_next = sel_reg;
        cx_next    = TIMING_INPUT_PIN_I;
        fall_next  = (fall_reg == 4'hf) ? 4'hf : fall_reg + 4'h1;
        if (cx_reg && !TIMING_INPUT_PIN_I)
            fall_next = 4'h0;
        sel_oh     = (sel_d_reg < 5'd19) ? (CHANNELS'(1) << sel_d_reg) : '0;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            {wc_reg, wi_reg, en_reg, en_d_reg, ien_reg, cx_reg} <= 6'h00;
            {sel_reg, sel_d_reg} <= 10'h000;
            rm_reg   <= 32'h0;
            fall_reg <= 4'hf;
        end
        else
        begin
            {wc_reg, wi_reg, en_reg, en_d_reg} <= {wc_next, wi_next, en_next, en_d_next};
            {ien_reg, cx_reg} <= {ien_next, cx_next};
            {sel_reg, sel_d_reg} <= {sel_next, sel_d_next};
            rm_reg   <= rm_next;
            fall_reg <= fall_next;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    sequence s_recent_fall;
        fall_reg <= 4'd8;
    endsequence

    a_drive_selected: assert property (en_d_reg |-> SENSOR_DRIVE_PIN_OE == sel_oh)
        else $error("drive enables differ from selected channel");
    a_drive_low: assert property (en_d_reg |-> (SENSOR_DRIVE_PIN_O & SENSOR_DRIVE_PIN_OE) == '0)
        else $error("selected drive pin not low");
    a_one_network: assert property ($onehot0(SENSOR_DRIVE_PIN_OE) || !en_d_reg)
        else $error("more than one network driven");
    a_port_passes: assert property (!en_d_reg |-> SENSOR_DRIVE_PIN_OE == $past(GPIO_OE)
        && SENSOR_DRIVE_PIN_O == $past(GPIO_O))
        else $error("port drive not passed through");
    a_timing_port: assert property (!en_d_reg |-> TIMING_INPUT_PIN_OE == $past(PORT_A_BIT1_PIN_OE))
        else $error("timing pad not under port control");
    a_timing_owned: assert property (en_d_reg |-> !TIMING_INPUT_PIN_OE)
        else $error("timing pad driven while enabled");
    a_irq_masked: assert property (!ien_reg |-> !IRQ)
        else $error("interrupt with enable clear");
    a_irq_after_fall: assert property ($rose(IRQ) |-> s_recent_fall)
        else $error("interrupt not tied to a timing fall");
    a_read_width: assert property (rm_reg != 32'h0 |-> (HRDATA & rm_reg) == 32'h0)
        else $error("unused read bits not zero");
endmodule

bind rfc_converter rfc_converter_asserts #(.CHANNELS(CHANNELS)) chk_i (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .IRQ(IRQ),
    .TIMING_INPUT_PIN_I(TIMING_INPUT_PIN_I), .PORT_A_BIT1_PIN_OE(PORT_A_BIT1_PIN_OE),
    .TIMING_INPUT_PIN_OE(TIMING_INPUT_PIN_OE), .GPIO_O(GPIO_O), .GPIO_OE(GPIO_OE),
    .SENSOR_DRIVE_PIN_O(SENSOR_DRIVE_PIN_O), .SENSOR_DRIVE_PIN_OE(SENSOR_DRIVE_PIN_OE));

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench: register bus tasks and conversion scenarios
`timescale 1ns/1ps
`default_nettype none

`include "rfc_defines.svh"

module tb_top;
    logic        clk_sys, srst, hsel, hwrite, pa_o, pa_oe, run;
    logic        hreadyout, hresp, irq, pa_in, tim_o, tim_oe, cx, pad;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [18:0] gpio_o, gpio_oe, drv_o, drv_oe;
    logic [14:0] cnt;
    logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'hfc};
    logic [4:0]  sels [5] = '{5'd0, 5'd7, 5'd18, 5'd19, 5'd31};
    int          half, err_total, compares;

    assign pad = tim_oe ? tim_o : cx;

    rfc_converter uut (.CLK_SYS(clk_sys), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .IRQ(irq), .TIMING_INPUT_PIN_I(pad), .PORT_A_BIT1_PIN_O(pa_o),
        .PORT_A_BIT1_PIN_OE(pa_oe), .PORT_A_BIT1_PIN_IN(pa_in), .TIMING_INPUT_PIN_O(tim_o),
        .TIMING_INPUT_PIN_OE(tim_oe), .GPIO_O(gpio_o), .GPIO_OE(gpio_oe),
        .SENSOR_DRIVE_PIN_O(drv_o), .SENSOR_DRIVE_PIN_OE(drv_oe));

    rc_network net_i (.clk(clk_sys), .drive_o(drv_o), .drive_oe(drv_oe), .run(run),
        .half(half), .cx(cx));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Single word transfer; read data taken at the edge ending the data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= `RFC_HTRANS_NONSEQ;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Count is one full timing period in system clocks
    task automatic chk_cnt(input int p);
        xfer(1'b0, `RFC_OFS_COUNT_LO, 32'h0);
        cnt[7:0] = rd[7:0];
        xfer(1'b0, `RFC_OFS_COUNT_HI, 32'h0);
        cnt[14:8] = rd[6:0];
        chk({17'h0, cnt}, 32'(p));
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        report_and_stop();
    end

    initial
    begin
        {srst, hsel, hwrite, pa_o, pa_oe, run} = 6'b110000;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, `RFC_HSIZE_WORD};
        {gpio_o, gpio_oe} = 38'h0;
        {half, err_total, compares} = {32'd12, 32'd0, 32'd0};
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        foreach (offs[i]) rdchk(offs[i], 32'h0);
        gpio_oe <= 19'h5a5a5;
        gpio_o  <= 19'h3c3c3;
        {pa_o, pa_oe} <= 2'b11;
        repeat (6) @(posedge clk_sys);
        chk({13'h0, drv_oe}, 32'h5a5a5);
        chk({13'h0, drv_o}, 32'h3c3c3);
        chk({31'h0, pa_in}, 32'h1);
        {gpio_oe, pa_oe} <= 20'h0;
        foreach (sels[i])
        begin
            xfer(1'b1, `RFC_OFS_CTRL, 32'h80 | sels[i]);
            repeat (2) @(posedge clk_sys);
            chk({13'h0, drv_oe}, sels[i] < 19 ? 32'h1 << sels[i] : 32'h0);
            chk({13'h0, drv_o & drv_oe}, 32'h0);
            chk({31'h0, tim_oe}, 32'h0);
        end
        xfer(1'b1, `RFC_OFS_CTRL, 32'h83);
        run <= 1'b1;
        repeat (200) @(posedge clk_sys);
        chk_cnt(0);
        xfer(1'b1, `RFC_OFS_IEN, 32'h40);
        xfer(1'b1, `RFC_OFS_CTRL, 32'hc3);
        wait_irq();
        chk({31'h0, irq}, 32'h1);
        rdchk(`RFC_OFS_CTRL, 32'h83);
        chk_cnt(24);
        rdchk(`RFC_OFS_IFLAG, 32'h40);
        repeat (100) @(posedge clk_sys);
        chk_cnt(24);
        xfer(1'b1, `RFC_OFS_IFLAG, 32'h40);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        rdchk(`RFC_OFS_IFLAG, 32'h0);
        half <= 9;
        xfer(1'b1, `RFC_OFS_IEN, 32'h0);
        repeat (50) @(posedge clk_sys);
        xfer(1'b1, `RFC_OFS_CTRL, 32'hc3);
        rd = 32'h40;
        for (int n = 0; n < 60 && rd[6] !== 1'b0; n++) xfer(1'b0, `RFC_OFS_CTRL, 32'h0);
        chk(rd, 32'h83);
        chk({31'h0, irq}, 32'h0);
        rdchk(`RFC_OFS_IFLAG, 32'h0);
        chk_cnt(18);
        xfer(1'b1, `RFC_OFS_IEN, 32'h40);
        xfer(1'b1, `RFC_OFS_CTRL, 32'hc3);
        repeat (10) @(posedge clk_sys);
        xfer(1'b1, `RFC_OFS_CTRL, 32'h83);
        repeat (100) @(posedge clk_sys);
        rdchk(`RFC_OFS_CTRL, 32'h83);
        chk_cnt(0);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, `RFC_OFS_CTRL, 32'h00);
        {run, gpio_oe} <= {1'b0, 19'h12345};
        repeat (4) @(posedge clk_sys);
        chk({13'h0, drv_oe}, 32'h12345);
        report_and_stop();
    end
endmodule

`default_nettype wire
